// ### fault_led_pkg.sv
// shared constants and types for the fault supervisor and status indicator
package fault_led_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_HZ = 40_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int HOLDOFF_MS = 50;          // least restart delay after a self-resetting fault
  localparam int HOLDOFF_CYC = HOLDOFF_MS * CYC_PER_MS;
  localparam int FAST_HALF_MS = 100;       // fast blink half period
  localparam int FAST_HALF_CYC = FAST_HALF_MS * CYC_PER_MS;
  localparam int SLOW_ON_MS = 300;         // slow blink lit time
  localparam int SLOW_ON_CYC = SLOW_ON_MS * CYC_PER_MS;
  localparam int SLOW_OFF_MS = 300;        // slow blink dark time
  localparam int SLOW_OFF_CYC = SLOW_OFF_MS * CYC_PER_MS;
  localparam int PAUSE_MS = 1500;          // dark pause between bursts
  localparam int PAUSE_CYC = PAUSE_MS * CYC_PER_MS;

  // ==========================================================
  // fault code space: bit n of a fault vector carries code n
  localparam int NUM_CODES = 21;
  localparam int CODE_W = 5;
  localparam logic [NUM_CODES-1:0] CODE_VALID = 21'h1F_FFFC;   // codes 2..20
  localparam logic [CODE_W-1:0] CODE_NONE = 5'h00;
  localparam logic [CODE_W-1:0] CODE_DRIVE_OVERLOAD = 5'h04;
  localparam logic [CODE_W-1:0] CODE_BATTERY_LOW = 5'h06;
  localparam logic [CODE_W-1:0] CODE_MAX = 5'h14;

  // ==========================================================
  // register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_LATCH_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_LIVE = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_LATCHED = 8'h1C;

  // control fields and reset values
  localparam int CTRL_FOLD_BIT = 0;        // 1: overload folds current back instead of faulting
  localparam int CTRL_BATT_BIT = 1;        // 1: low battery fault is enabled
  localparam int CTRL_SWEN_BIT = 2;        // software enable
  localparam logic [2:0] CTRL_RESET = 3'h4;
  localparam logic [NUM_CODES-1:0] LATCH_MASK_RESET = 21'h1F_FE70;

  // interrupt events
  localparam int IRQ_W = 3;
  localparam int IRQ_FAULT_BIT = 0;        // a fault appeared
  localparam int IRQ_RESUME_BIT = 1;       // output stage came back on
  localparam int IRQ_FOLD_BIT = 2;         // current foldback began

  // ==========================================================
  // indicator sequencer states, gray along LED_FAST, LED_ON, LED_OFF, LED_PAUSE
  typedef enum logic [2:0] {
    LED_STEADY = 3'b000,
    LED_FAST = 3'b001,
    LED_ON = 3'b011,
    LED_OFF = 3'b010,
    LED_PAUSE = 3'b110
  } led_state_t;

  // status word as read by software
  typedef struct packed {
    logic [20:0] zero;
    logic holdoff;
    logic foldback;
    logic enabled;
    logic stage_on;
    logic [1:0] pad;
    logic [CODE_W-1:0] code;
  } status_word_t;

endpackage

// ### sync3_filter.sv
// three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module sync3_filter
  import fault_led_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // asynchronous inputs and filtered result
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // ==========================================================
  // synchroniser chain; stage one feeds only stage two
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // accept a bit only when stages two and three agree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dout <= RESET_VAL;
    end else begin
      dout <= (s3_reg & ~(s2_reg ^ s3_reg)) | (dout & (s2_reg ^ s3_reg));
    end
  end

endmodule

// ### fault_led_supervisor.sv
// fault supervisor, output stage gate and front panel status indicator sequencer
// Function
// - enabled and healthy shows steady on; disabled and healthy fast-blinks with stage off
// - a reported fault slow-blinks in bursts, blink count equals the code, pause between
// - codes 2,3,4,5,7,8,9,10 are temperatures, overloads, bus voltages, short, overcurrent
// - code 6 is the optional low battery fault, code 11 a Hall sensor fault
// - feedback device errors take codes 12 through 17
// - code 18 card watchdog, 19 position error, 20 option card fault
// - latched class faults capture their source and hold it; others are not held
// - any fault turns the output stage off, then the code is shown
// - a non-latched fault re-enables the stage by itself once it goes away
// - latched faults clear only while enable is off, or on full reset
// - after a self-resetting fault clears the stage stays off 50 to 100 ms
// - with several faults active only the highest priority one is shown
// - after the shown fault clears and enable cycles, the next fault is shown
// - drive overload either folds the current limit back or faults, as configured
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
module fault_led_supervisor
  import fault_led_pkg::*;
#(
  parameter int HOLDOFF_CYCLES = HOLDOFF_CYC,
  parameter int FAST_HALF_CYCLES = FAST_HALF_CYC,
  parameter int SLOW_ON_CYCLES = SLOW_ON_CYC,
  parameter int SLOW_OFF_CYCLES = SLOW_OFF_CYC,
  parameter int PAUSE_CYCLES = PAUSE_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // protection detectors and enable pin
  input wire logic [NUM_CODES-1:0] FAULT_IN,
  input wire logic ENABLE_B,
  // register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // power stage, current limit, indicator and interrupt
  output logic STAGE_EN,
  output logic LIMIT_REDUCE,
  output logic LED,
  output logic IRQ
);

  logic [NUM_CODES-1:0] fault_q;
  logic enable_b_q;
  logic [2:0] ctrl_reg;
  logic [NUM_CODES-1:0] latch_mask_reg;
  logic [NUM_CODES-1:0] latched_reg;
  logic [NUM_CODES-1:0] live;
  logic [NUM_CODES-1:0] active;
  logic [CODE_W-1:0] best_code;
  logic [CODE_W-1:0] disp_code_reg;
  logic [31:0] holdoff_reg;
  logic fault_any;
  logic nl_any;
  logic enabled;
  logic fold;
  logic stage_next;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_en_reg;
  logic [IRQ_W-1:0] events;
  logic fault_any_d_reg;
  led_state_t led_state_reg;
  led_state_t led_state_next;
  logic [31:0] timer_reg;
  logic [CODE_W-1:0] blink_cnt_reg;
  logic fast_phase_reg;
  status_word_t status_word;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  // ==========================================================
  // input synchronisers
  sync3_filter #(.W(NUM_CODES), .RESET_VAL('0)) u_fault_sync (
    .clk(CLK),
    .rst_b(RST_B),
    .din(FAULT_IN),
    .dout(fault_q)
  );

  sync3_filter #(.W(1), .RESET_VAL(1'b1)) u_enable_sync (
    .clk(CLK),
    .rst_b(RST_B),
    .din(ENABLE_B),
    .dout(enable_b_q)
  );

  // ==========================================================
  // fault classification
  // bit n of the fault vector is code n: 2..10 power and thermal, 11 hall,
  // 12..17 feedback device, 18..20 option card and position
  always_comb begin
    live = fault_q & CODE_VALID;
    if (!ctrl_reg[CTRL_BATT_BIT]) begin
      live[CODE_BATTERY_LOW] = 1'b0;
    end
    if (ctrl_reg[CTRL_FOLD_BIT]) begin
      live[CODE_DRIVE_OVERLOAD] = 1'b0;
    end
  end

  // latched class faults plus the non-latched ones still present
  assign active = latched_reg | (live & ~latch_mask_reg);
  assign fault_any = |active;
  assign nl_any = |(live & ~latch_mask_reg);
  assign enabled = !enable_b_q && ctrl_reg[CTRL_SWEN_BIT];
  assign fold = ctrl_reg[CTRL_FOLD_BIT] && fault_q[CODE_DRIVE_OVERLOAD];

  // lowest numbered active code wins
  always_comb begin
    best_code = CODE_NONE;
    for (int i = NUM_CODES - 1; i >= 0; i--) begin
      if (active[i]) begin
        best_code = CODE_W'(i);
      end
    end
  end

  // ==========================================================
  // latched fault capture; a new fault wins over the clear
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      latched_reg <= '0;
    end else if (enable_b_q) begin
      latched_reg <= live & latch_mask_reg;
    end else begin
      latched_reg <= latched_reg | (live & latch_mask_reg);
    end
  end

  // restart delay after a self-resetting fault goes away
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      holdoff_reg <= '0;
    end else if (nl_any) begin
      holdoff_reg <= 32'(HOLDOFF_CYCLES);
    end else if (holdoff_reg != 0) begin
      holdoff_reg <= holdoff_reg - 32'h0000_0001;
    end
  end

  // shown code sticks until that fault is no longer active
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      disp_code_reg <= CODE_NONE;
    end else if (disp_code_reg == CODE_NONE || !active[disp_code_reg]) begin
      disp_code_reg <= best_code;
    end
  end

  // ==========================================================
  // power stage and current limit
  assign stage_next = enabled && !fault_any && (holdoff_reg == 0);

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      STAGE_EN <= 1'b0;
      LIMIT_REDUCE <= 1'b0;
    end else begin
      STAGE_EN <= stage_next;
      LIMIT_REDUCE <= fold;
    end
  end

  // ==========================================================
  // indicator sequencer
  always_comb begin
    led_state_next = led_state_reg;
    case (led_state_reg)
      LED_STEADY, LED_FAST: begin
        if (disp_code_reg != CODE_NONE) begin
          led_state_next = LED_ON;
        end else if (enabled) begin
          led_state_next = LED_STEADY;
        end else begin
          led_state_next = LED_FAST;
        end
      end
      LED_ON: begin
        if (timer_reg == 0) begin
          led_state_next = LED_OFF;
        end
      end
      LED_OFF: begin
        if (timer_reg == 0) begin
          led_state_next = (blink_cnt_reg >= disp_code_reg) ? LED_PAUSE : LED_ON;
        end
      end
      LED_PAUSE: begin
        if (timer_reg == 0) begin
          led_state_next = (disp_code_reg == CODE_NONE) ? LED_STEADY : LED_ON;
        end
      end
      default: begin
        led_state_next = LED_STEADY;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      led_state_reg <= LED_STEADY;
    end else begin
      led_state_reg <= led_state_next;
    end
  end

  // phase timer, reloaded on every state entry
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      timer_reg <= '0;
    end else if (led_state_next != led_state_reg) begin
      case (led_state_next)
        LED_ON: timer_reg <= 32'(SLOW_ON_CYCLES - 1);
        LED_OFF: timer_reg <= 32'(SLOW_OFF_CYCLES - 1);
        LED_PAUSE: timer_reg <= 32'(PAUSE_CYCLES - 1);
        default: timer_reg <= 32'(FAST_HALF_CYCLES - 1);
      endcase
    end else if (timer_reg != 0) begin
      timer_reg <= timer_reg - 32'h0000_0001;
    end else if (led_state_reg == LED_FAST) begin
      timer_reg <= 32'(FAST_HALF_CYCLES - 1);
    end
  end

  // fast blink phase toggles at each half period
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      fast_phase_reg <= 1'b0;
    end else if (led_state_reg != LED_FAST) begin
      fast_phase_reg <= 1'b0;
    end else if (timer_reg == 0) begin
      fast_phase_reg <= !fast_phase_reg;
    end
  end

  // blinks given in the current burst
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      blink_cnt_reg <= '0;
    end else if (led_state_reg != LED_ON && led_state_next == LED_ON) begin
      blink_cnt_reg <= (led_state_reg == LED_OFF) ? blink_cnt_reg + 5'h01 : 5'h01;
    end
  end

  // indicator output
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      LED <= 1'b0;
    end else begin
      LED <= (led_state_next == LED_STEADY) || (led_state_next == LED_ON) ||
             (led_state_reg == LED_FAST && led_state_next == LED_FAST && fast_phase_reg);
    end
  end

  // ==========================================================
  // control registers written by software
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_reg <= CTRL_RESET;
      latch_mask_reg <= LATCH_MASK_RESET;
      irq_en_reg <= '0;
    end else if (WR) begin
      case (ADDR)
        OFS_CTRL: ctrl_reg <= WDATA[2:0];
        OFS_LATCH_MASK: latch_mask_reg <= WDATA[NUM_CODES-1:0] & CODE_VALID;
        OFS_IRQ_ENABLE: irq_en_reg <= WDATA[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // interrupt events: sticky, set wins over write-one clear
  assign events = {fold && !LIMIT_REDUCE, stage_next && !STAGE_EN, fault_any && !fault_any_d_reg};

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      fault_any_d_reg <= 1'b0;
      irq_status_reg <= '0;
      IRQ <= 1'b0;
    end else begin
      fault_any_d_reg <= fault_any;
      if (WR && ADDR == OFS_IRQ_CLEAR) begin
        irq_status_reg <= (irq_status_reg & ~WDATA[IRQ_W-1:0]) | events;
      end else begin
        irq_status_reg <= irq_status_reg | events;
      end
      IRQ <= |(irq_status_reg & irq_en_reg);
    end
  end

  // ==========================================================
  // read path, data stands one cycle after the strobe
  always_comb begin
    status_word = '0;
    status_word.holdoff = (holdoff_reg != 0);
    status_word.foldback = LIMIT_REDUCE;
    status_word.enabled = enabled;
    status_word.stage_on = STAGE_EN;
    status_word.code = disp_code_reg;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      RDATA <= '0;
    end else if (RD) begin
      case (ADDR)
        OFS_CTRL: RDATA <= {29'h0000_0000, ctrl_reg};
        OFS_LATCH_MASK: RDATA <= {11'h000, latch_mask_reg};
        OFS_STATUS: RDATA <= status_word;
        OFS_IRQ_STATUS: RDATA <= {29'h0000_0000, irq_status_reg};
        OFS_IRQ_ENABLE: RDATA <= {29'h0000_0000, irq_en_reg};
        OFS_LIVE: RDATA <= {11'h000, live};
        OFS_LATCHED: RDATA <= {11'h000, latched_reg};
        default: RDATA <= '0;
      endcase
    end else begin
      RDATA <= '0;
    end
  end

  // ==========================================================
  // checks
  sequence burst_last_off;
    led_state_reg == LED_OFF && timer_reg == 0 && disp_code_reg != CODE_NONE && blink_cnt_reg >= disp_code_reg;
  endsequence

  sequence burst_done;
    burst_last_off ##1 led_state_reg == LED_PAUSE;
  endsequence

  chk_led_steady: assert property (
    (led_state_reg == LED_STEADY && disp_code_reg == CODE_NONE && enabled) |=> LED)
    else $error("indicator not lit while enabled and healthy");

  chk_burst_count: assert property (
    burst_done |-> blink_cnt_reg == $past(disp_code_reg))
    else $error("burst blink count differs from fault code");

  chk_latch_hold: assert property (
    !enable_b_q |=> ((latched_reg & $past(latched_reg)) == $past(latched_reg)))
    else $error("latched fault lost while enabled");

  chk_stage_fault: assert property (
    fault_any |=> !STAGE_EN)
    else $error("output stage on during a fault");

  chk_latch_clear: assert property (
    (enable_b_q && !(|(live & latch_mask_reg))) |=> latched_reg == '0)
    else $error("latched faults not cleared while disabled");

  chk_holdoff_gate: assert property (
    $fell(nl_any) |-> ##1 (holdoff_reg == 32'(HOLDOFF_CYCLES - 1)) ##1 !STAGE_EN)
    else $error("restart delay not applied");

  chk_show_best: assert property (
    ($changed(disp_code_reg) && disp_code_reg != CODE_NONE) |-> disp_code_reg == $past(best_code))
    else $error("shown code is not the highest priority");

  chk_foldback_limit: assert property (
    fold |=> (LIMIT_REDUCE && !active[CODE_DRIVE_OVERLOAD]))
    else $error("foldback not applied or overload faulted");

endmodule

// ### fault_panel_model.sv
// detector, enable pin and indicator observer model for the fault supervisor
`timescale 1ns/1ps
module fault_panel_model
  import fault_led_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // requests from the bench
  input wire logic [NUM_CODES-1:0] fault_req,
  input wire logic enable_req,
  // pins toward the block
  output logic [NUM_CODES-1:0] fault_pin,
  output logic enable_b_pin,
  // indicator observation
  input wire logic led,
  output logic [7:0] blink_count,
  output logic [7:0] burst_seen
);
  logic [7:0] run_cnt;
  logic [7:0] dark_cnt;
  logic led_d;

  // ==========================================================
  // pins
  // detector levels follow the bench requests
  assign fault_pin = fault_req;
  // the controller drops enable to clear held faults
  assign enable_b_pin = ~enable_req;

  // ==========================================================
  // burst counter
  // count lit pulses; a dark run longer than a slow blink gap closes a burst
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      led_d <= 1'b0;
      run_cnt <= 8'h00;
      dark_cnt <= 8'h00;
      blink_count <= 8'h00;
      burst_seen <= 8'h00;
    end else begin
      led_d <= led;
      if (led && !led_d) run_cnt <= run_cnt + 8'h01;
      if (led) dark_cnt <= 8'h00;
      else if (dark_cnt != 8'hFF) dark_cnt <= dark_cnt + 8'h01;
      if (!led && dark_cnt == 8'h06) begin
        blink_count <= run_cnt;
        run_cnt <= 8'h00;
        burst_seen <= burst_seen + 8'h01;
      end
    end
  end
endmodule

// ### test_fault_led_supervisor.sv
// self-checking bench for the fault supervisor and status indicator
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_fault_led_supervisor
  import fault_led_pkg::*;
;
  logic clk, rst_b, en_req, enable_b, wr_s, rd_s;
  logic [NUM_CODES-1:0] fault_req, fault_pin;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdata, rdata;
  logic stage_en, limit_reduce, led, irq;
  logic [7:0] blink_count, burst_seen;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;

  // ==========================================================
  // clock, design and partner
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  fault_led_supervisor #(.HOLDOFF_CYCLES(20), .FAST_HALF_CYCLES(4), .SLOW_ON_CYCLES(3),
    .SLOW_OFF_CYCLES(3), .PAUSE_CYCLES(10)) uut (.CLK(clk), .RST_B(rst_b), .FAULT_IN(fault_pin),
    .ENABLE_B(enable_b), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
    .STAGE_EN(stage_en), .LIMIT_REDUCE(limit_reduce), .LED(led), .IRQ(irq));
  fault_panel_model partner (.clk(clk), .rst_b(rst_b), .fault_req(fault_req), .enable_req(en_req),
    .fault_pin(fault_pin), .enable_b_pin(enable_b), .led(led), .blink_count(blink_count),
    .burst_seen(burst_seen));

  // ==========================================================
  // shared tasks
  task results;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
    end
  endtask
  task rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 d = rdata;
    end
  endtask
  task wait_stage(input logic v, input int lim);
    int i;
    begin
      i = 0;
      while (stage_en !== v && i < lim) begin
        @(posedge clk);
        #1 i++;
      end
      `CHK(stage_en, v)
    end
  endtask
  task cycle_en;
    begin
      @(posedge clk);
      en_req <= 1'b0;
      repeat (10) @(posedge clk);
      en_req <= 1'b1;
    end
  endtask
  task get_burst(input int n);
    logic [7:0] s;
    int i;
    begin
      s = burst_seen;
      i = 0;
      while (burst_seen !== s + 8'h02 && i < 600) begin
        @(posedge clk);
        #1 i++;
      end
      `CHK(blink_count, n[7:0])
    end
  endtask

  // ==========================================================
  // scenarios
  // reset values, disabled fast blink, then steady on once enabled
  task t_idle;
    logic [31:0] d;
    logic prev;
    int tog;
    begin
      rd(OFS_CTRL, d); `CHK(d, 32'h0000_0004)
      rd(OFS_LATCH_MASK, d); `CHK(d, 32'h001F_FE70)
      rd(8'h20, d); `CHK(d, 32'h0000_0000)
      tog = 0;
      prev = led;
      for (int i = 0; i < 40; i++) begin
        @(posedge clk);
        #1 if (led !== prev) tog++;
        prev = led;
      end
      `CHK((tog >= 8 && tog <= 10), 1'b1)
      `CHK(stage_en, 1'b0)
      @(posedge clk);
      en_req <= 1'b1;
      wait_stage(1'b1, 20);
      tog = 0;
      repeat (20) begin
        @(posedge clk);
        #1 if (led !== 1'b1) tog++;
      end
      `CHK(tog, 0)
      $display("idle test done");
    end
  endtask
  // one fault: stage off, code shown and blinked, then cleared by its class
  task t_code(input int n);
    logic [31:0] d;
    begin
      @(posedge clk);
      fault_req[n] <= 1'b1;
      wait_stage(1'b0, 12);
      rd(OFS_STATUS, d); `CHK(d[4:0], n[4:0])
      get_burst(n);
      @(posedge clk);
      fault_req[n] <= 1'b0;
      if (LATCH_MASK_RESET[n]) begin
        repeat (30) @(posedge clk);
        #1 `CHK(stage_en, 1'b0)
        rd(OFS_LATCHED, d); `CHK(d[n], 1'b1)
        cycle_en;
        wait_stage(1'b1, 60);
      end else begin
        repeat (20) @(posedge clk);
        #1 `CHK(stage_en, 1'b0)
        rd(OFS_LATCHED, d); `CHK(d[n], 1'b0)
        wait_stage(1'b1, 30);
      end
      $display("code %0d test done", n);
    end
  endtask
  // two faults at once, then the next one after enable cycles
  task t_priority;
    logic [31:0] d;
    begin
      @(posedge clk);
      fault_req[12] <= 1'b1;
      fault_req[9] <= 1'b1;
      wait_stage(1'b0, 12);
      rd(OFS_STATUS, d); `CHK(d[4:0], 5'h09)
      @(posedge clk);
      fault_req[9] <= 1'b0;
      cycle_en;
      repeat (10) @(posedge clk);
      rd(OFS_STATUS, d); `CHK(d[4:0], 5'h0C)
      @(posedge clk);
      fault_req[12] <= 1'b0;
      cycle_en;
      wait_stage(1'b1, 60);
      $display("priority test done");
    end
  endtask
  // overload with foldback selected: limit drops, no fault, interrupt path
  task t_fold;
    logic [31:0] d;
    begin
      wr(OFS_CTRL, 32'h0000_0005);
      @(posedge clk);
      fault_req[4] <= 1'b1;
      repeat (10) @(posedge clk);
      #1 `CHK(limit_reduce, 1'b1)
      `CHK(stage_en, 1'b1)
      `CHK(irq, 1'b0)
      rd(OFS_IRQ_STATUS, d); `CHK(d[IRQ_FOLD_BIT], 1'b1)
      wr(OFS_IRQ_ENABLE, 32'h0000_0004);
      repeat (2) @(posedge clk);
      #1 `CHK(irq, 1'b1)
      wr(OFS_IRQ_CLEAR, 32'h0000_0007);
      repeat (2) @(posedge clk);
      #1 `CHK(irq, 1'b0)
      @(posedge clk);
      fault_req[4] <= 1'b0;
      repeat (8) @(posedge clk);
      wr(OFS_CTRL, 32'h0000_0004);
      repeat (10) @(posedge clk);
      #1 `CHK(limit_reduce, 1'b0)
      $display("foldback test done");
    end
  endtask

  // ==========================================================
  // main sequence and hang guard
  initial begin
    rst_b = 1'b0;
    fault_req = '0;
    en_req = 1'b0;
    addr = '0;
    wdata = '0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_idle;
    for (int n = 2; n <= 5; n++) t_code(n);
    wr(OFS_CTRL, 32'h0000_0006);
    t_code(6);
    wr(OFS_CTRL, 32'h0000_0004);
    for (int n = 7; n <= 10; n++) t_code(n);
    t_code(11);
    for (int n = 12; n <= 17; n++) t_code(n);
    for (int n = 18; n <= 20; n++) t_code(n);
    t_priority;
    t_fold;
    results;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      results;
    end
  end
endmodule
